// ==== tb/qcac_host_model.sv ====
`default_nettype none
module qcac_host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i,
    output var  logic        wr_o,
    output var  logic        rd_o,
    output var  logic [6:0]  addr_o,
    output var  logic [31:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // register port accesses, released lines show inverted values
    // ------------------------------------------------------------------
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 7'h00;
        wdata_o = 32'h0;
    end
    task automatic write(input logic [6:0] a, input logic [31:0] d);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
        @(negedge clk_i);
    endtask
    task automatic read(input logic [6:0] a, output logic [31:0] d, output logic ok);
        addr_o = a;
        rd_o = 1'b1;
        ok = 1'b0;
        d = 32'h0;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        repeat (4) begin
            if (!ok && rvalid_i === 1'b1) begin
                ok = 1'b1;
                d = rdata_i;
            end
            @(negedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/qcac_monitor.sv ====
`default_nettype none
`include "qcac_map.svh"
module qcac_monitor #(
    parameter logic [20:0] STST_CYCLES = `QCAC_STST_CYCLES
) (
    input wire logic                SYS_CLK_I,
    input wire logic                RESET_N_I,
    input wire logic                REG_WR_I,
    input wire logic                REG_RD_I,
    input wire logic [6:0]          REG_ADDR_I,
    input wire logic [31:0]         REG_WDATA_I,
    input wire logic                STEP_I,
    input wire logic [4:0]          CUR_SCALE_I,
    input wire logic [4:0]          LOW_SCALE_LIMIT_I,
    input wire logic [7:0]          AUTO_AMPL_I,
    input wire logic [31:0]         REG_RDATA_O,
    input wire logic                REG_RVALID_O,
    input wire logic [7:0]          BASE_AMPLITUDE_O,
    input wire logic [4:0]          CS_ACTUAL_O,
    input wire logic                STANDSTILL_O,
    input wire qcac_pkg::qcac_cfg_t CFG_O
);
    timeunit 1ns;
    timeprecision 1ns;
    import qcac_pkg::*;
    // ------------------------------------------------------------------
    // idle counter since last step
    // ------------------------------------------------------------------
    logic [21:0] idle_r;
    logic [21:0] idle_nxt;
    logic        seen_r;
    wire  [21:0] stst_w   = {1'b0, STST_CYCLES};
    wire         floor_on = CFG_O.autoscale && (CFG_O.offset == 8'h00);
    wire         unmapped = (REG_ADDR_I != 7'h6F) && (REG_ADDR_I != 7'h70)
                            && (REG_ADDR_I != 7'h71);
    assign idle_nxt = STEP_I ? 22'h000000 : idle_r + {21'h000000, ~&idle_r};
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            idle_r <= 22'h000000;
            seen_r <= 1'b0;
        end else begin
            idle_r <= idle_nxt;
            seen_r <= seen_r | STEP_I;
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    sequence cs_steady;
        ($stable(CUR_SCALE_I) && $stable(LOW_SCALE_LIMIT_I) && $stable(CFG_O)) [*3];
    endsequence
    sequence ampl_steady;
        ($stable(AUTO_AMPL_I) && $stable(CFG_O)) [*3];
    endsequence
    AST_RVALID: assert property (REG_RD_I |=> REG_RVALID_O)
        else $error("read without valid");
    AST_NO_RVALID: assert property (!REG_RD_I |=> !REG_RVALID_O)
        else $error("valid without read");
    AST_UNMAPPED: assert property (REG_RD_I && unmapped |=> REG_RDATA_O == 32'h0)
        else $error("unmapped read not zero");
    AST_STATUS_ZERO: assert property (REG_RD_I && REG_ADDR_I == 7'h6F
        |=> REG_RDATA_O[29:21] == 9'h000 && REG_RDATA_O[15:0] == 16'h0000)
        else $error("status spare bits set");
    AST_CFG_WRITE: assert property (REG_WR_I && REG_ADDR_I == 7'h70
        |-> ##2 CFG_O == ($past(REG_WDATA_I, 2) & 32'hFF3FFFFF))
        else $error("config write not applied");
    AST_STST_HOLD: assert property (seen_r && idle_r >= 22'h1 && idle_r <= stst_w
        |-> !STANDSTILL_O)
        else $error("standstill too early");
    AST_STST_SET: assert property (seen_r && idle_r == stst_w + 22'h1 |-> STANDSTILL_O)
        else $error("standstill missing");
    AST_CS_FOLLOW: assert property (cs_steady ##0
        (!floor_on || CUR_SCALE_I >= LOW_SCALE_LIMIT_I) |-> CS_ACTUAL_O == CUR_SCALE_I)
        else $error("scale not followed");
    AST_CS_FLOOR: assert property (cs_steady ##0
        (floor_on && CUR_SCALE_I < LOW_SCALE_LIMIT_I) |-> CS_ACTUAL_O == LOW_SCALE_LIMIT_I)
        else $error("scale below floor");
    AST_AMPL_AUTO: assert property (ampl_steady ##0 CFG_O.autoscale
        |-> BASE_AMPLITUDE_O == AUTO_AMPL_I)
        else $error("auto amplitude not passed");
endmodule
bind qcac_top qcac_monitor #(.STST_CYCLES(STST_CYCLES)) qcac_monitor_i (
    .SYS_CLK_I, .RESET_N_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I,
    .STEP_I, .CUR_SCALE_I, .LOW_SCALE_LIMIT_I, .AUTO_AMPL_I, .REG_RDATA_O,
    .REG_RVALID_O, .BASE_AMPLITUDE_O, .CS_ACTUAL_O, .STANDSTILL_O, .CFG_O
);
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import qcac_pkg::*;
    localparam logic [20:0] STST = 21'h000040;
    int          num_errors = 0;
    int          compares = 0;
    int          half_q[$] = '{1024, 683, 512, 410};
    logic [31:0] rng = 32'h5064969A;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        step = 1'b0;
    logic        quiet = 1'b0;
    logic        aval = 1'b0;
    logic [4:0]  cs = 5'h00;
    logic [4:0]  low = 5'h00;
    logic [7:0]  aampl = 8'h00;
    logic [7:0]  aslope = 8'h00;
    logic [7:0]  otp = 8'h00;
    logic        wr, rd, rvalid, pwm, stst_o;
    logic [6:0]  addr;
    logic [31:0] wdata, rdata, d;
    logic [7:0]  ampl, seed;
    logic [4:0]  cs_act;
    qcac_cfg_t   cfg;

    always #5 clk = ~clk;

    qcac_top #(.STST_CYCLES(STST)) qcac_top_i (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .STEP_I(step), .QUIET_ACTIVE_I(quiet),
        .CUR_SCALE_I(cs), .LOW_SCALE_LIMIT_I(low), .AUTO_AMPL_I(aampl),
        .AUTO_SLOPE_I(aslope), .AUTO_SLOPE_VALID_I(aval), .OTP_SLOPE_I(otp),
        .OTP_SLOPE_VALID_I(1'b1), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .PWM_CYCLE_O(pwm), .BASE_AMPLITUDE_O(ampl), .CS_ACTUAL_O(cs_act),
        .STANDSTILL_O(stst_o), .SEED_SLOPE_O(seed), .CFG_O(cfg)
    );
    qcac_host_model qcac_host_model_i (
        .clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wdata)
    );
    // ------------------------------------------------------------------
    // helpers and reference model
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic int amp_m(int o, int c, int s, int iv);
        int v;
        v = (s * 256) / iv;
        v = ((o * (c + 1)) >> 5) + ((v > 255) ? 255 : v);
        return (v > 255) ? 255 : v;
    endfunction
    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse();
        step = 1'b1;
        @(negedge clk);
        step = 1'b0;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [31:0] e);
        logic ok;
        qcac_host_model_i.read(a, d, ok);
        if (ok !== 1'b1) begin
            num_errors++;
            end_of_test();
        end else begin
            check(d, e);
        end
    endtask
    task automatic gap(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pwm !== 1'b1 && n < 2100);
        if (n >= 2100) begin
            num_errors++;
            end_of_test();
        end
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] w;
        logic [31:0] r;
        int o, s, c, n, m;
        r = xs();
        otp = r[7:0];
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        cyc(2);
        rd_chk(7'h70, {8'hC8, 8'h0D, otp, 8'h24});
        rd_chk(7'h71, otp);
        rd_chk(7'h05, 32'h0);
        qcac_host_model_i.write(7'h6F, 32'hFFFFFFFF);
        rd_chk(7'h70, {8'hC8, 8'h0D, otp, 8'h24});
        qcac_host_model_i.write(7'h70, 32'hFFFFFFFF);
        rd_chk(7'h70, 32'hFF3FFFFF);
        $display("end of test: registers");
        r = xs();
        cs = r[4:0];
        quiet = r[5];
        pulse();
        cyc(4);
        rd_chk(7'h6F, {1'b0, quiet, 9'h000, cs, 16'h0000});
        cyc(STST + 8);
        quiet = ~quiet;
        rd_chk(7'h6F, {1'b1, quiet, 9'h000, cs, 16'h0000});
        check(stst_o, 1'b1);
        $display("end of test: status");
        for (int f = 0; f < 4; f++) begin
            r = xs();
            o = (f == 0) ? 255 : r[7:0];
            s = (f == 0) ? 255 : r[15:8];
            c = (f == 0) ? 31 : r[20:16];
            qcac_host_model_i.write(7'h70, {8'hC8, 6'h02, f[1:0], s[7:0], o[7:0]});
            gap(n);
            gap(n);
            gap(n);
            gap(m);
            check(n + m, half_q[f]);
            cs = c[4:0];
            repeat (3) begin
                pulse();
                cyc(39);
            end
            check(ampl, amp_m(o, c, s, 40));
            check(cs_act, c);
            rd_chk(7'h71, s);
        end
        $display("end of test: manual amplitude");
        low = 5'h14;
        cs = 5'h05;
        r = xs();
        aampl = r[7:0];
        aslope = r[15:8];
        w = {8'hC8, 8'h0D, s[7:0], 8'h00};
        qcac_host_model_i.write(7'h70, w);
        quiet = 1'b1;
        cyc(6);
        check(cfg, w);
        check(cs_act, 5'h14);
        check(ampl, aampl);
        rd_chk(7'h71, s);
        qcac_host_model_i.write(7'h70, w | 32'h10);
        cyc(6);
        check(cs_act, 5'h05);
        aval = 1'b1;
        @(negedge clk);
        aval = 1'b0;
        cyc(3);
        rd_chk(7'h71, aslope);
        check(seed, aslope);
        $display("end of test: automatic scaling");
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== verilog/qcac_divider.sv ====
`default_nettype none

`include "qcac_map.svh"

module qcac_divider (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [15:0] num_i,
    input  wire logic [20:0] den_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [15:0]      quot_o
);
    import qcac_pkg::*;

    // ------------------------------------------------------------------------
    // restoring divider, one quotient bit per clock
    // ------------------------------------------------------------------------
    qcac_div_state_t state_r;
    logic [15:0]     num_r;
    logic [20:0]     den_r;
    logic [21:0]     rem_r;
    logic [15:0]     q_r;
    logic [4:0]      cnt_r;

    wire logic [21:0] rem_sh  = {rem_r[20:0], num_r[15]};
    wire logic        fits    = (rem_sh >= {1'b0, den_r});
    wire logic [21:0] rem_nxt = fits ? (rem_sh - {1'b0, den_r}) : rem_sh;
    wire logic [15:0] q_nxt   = {q_r[14:0], fits};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= QCAC_DIV_IDLE;
            num_r   <= 16'h0000;
            den_r   <= 21'h000001;
            rem_r   <= 22'h000000;
            q_r     <= 16'h0000;
            cnt_r   <= 5'h00;
            done_o  <= 1'b0;
            quot_o  <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            unique case (state_r)
                QCAC_DIV_IDLE: begin
                    if (start_i) begin
                        num_r   <= num_i;
                        den_r   <= den_i;
                        rem_r   <= 22'h000000;
                        q_r     <= 16'h0000;
                        cnt_r   <= 5'h10;
                        state_r <= QCAC_DIV_RUN;
                    end
                end
                QCAC_DIV_RUN: begin
                    num_r <= {num_r[14:0], 1'b0};
                    rem_r <= rem_nxt;
                    q_r   <= q_nxt;
                    cnt_r <= cnt_r - 5'h01;
                    if (cnt_r == 5'h01) begin
                        quot_o  <= q_nxt;
                        done_o  <= 1'b1;
                        state_r <= QCAC_DIV_IDLE;
                    end
                end
            endcase
        end
    end

    assign busy_o = (state_r == QCAC_DIV_RUN);

endmodule

`default_nettype wire

// ==== verilog/qcac_map.svh ====
`ifndef QCAC_MAP_SVH
`define QCAC_MAP_SVH

// ----------------------------------------------------------------------------
// register indices (register port address width 7)
// ----------------------------------------------------------------------------
`define QCAC_ADDR_STATE_FLAGS     7'h6F
`define QCAC_ADDR_AMPL_CONFIG     7'h70
`define QCAC_ADDR_TUNED_SLOPE     7'h71

// ----------------------------------------------------------------------------
// chopper_amplitude_config field positions
// ----------------------------------------------------------------------------
`define QCAC_OFS_LSB              0
`define QCAC_OFS_MSB              7
`define QCAC_GRAD_LSB             8
`define QCAC_GRAD_MSB             15
`define QCAC_FREQ_LSB             16
`define QCAC_FREQ_MSB             17
`define QCAC_AUTOSCALE_BIT        18
`define QCAC_AUTOGRAD_BIT         19
`define QCAC_FREEWHEEL_LSB        20
`define QCAC_FREEWHEEL_MSB        21
`define QCAC_REG_LSB              24
`define QCAC_REG_MSB              27
`define QCAC_LIM_LSB              28
`define QCAC_LIM_MSB              31

// ----------------------------------------------------------------------------
// driver_state_flags field positions
// ----------------------------------------------------------------------------
`define QCAC_STST_BIT             31
`define QCAC_QUIET_BIT            30
`define QCAC_CS_LSB               16
`define QCAC_CS_MSB               20

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define QCAC_RST_OFS              8'h24
`define QCAC_RST_GRAD             8'h00
`define QCAC_RST_FREQ             2'h1
`define QCAC_RST_AUTOSCALE        1'b1
`define QCAC_RST_AUTOGRAD         1'b1
`define QCAC_RST_FREEWHEEL        2'h0
`define QCAC_RST_REG              4'h8
`define QCAC_RST_LIM              4'hC

// ----------------------------------------------------------------------------
// pwm period in half clocks per frequency code, and timing
// ----------------------------------------------------------------------------
`define QCAC_HALF_PERIOD_00       11'h400
`define QCAC_HALF_PERIOD_01       11'h2AB
`define QCAC_HALF_PERIOD_10       11'h200
`define QCAC_HALF_PERIOD_11       11'h19A
`define QCAC_STST_CYCLES          21'h100000
`define QCAC_SLOPE_SHIFT          8
`define QCAC_OFS_SHIFT            5
`define QCAC_AMPL_MAX             8'hFF

`endif

// ==== verilog/qcac_pkg.sv ====
`default_nettype none

package qcac_pkg;

    // ------------------------------------------------------------------------
    // configuration word
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] lim;
        logic [3:0] regul;
        logic [1:0] rsvd;
        logic [1:0] freewheel;
        logic       autograd;
        logic       autoscale;
        logic [1:0] freq_sel;
        logic [7:0] slope;
        logic [7:0] offset;
    } qcac_cfg_t;

    // ------------------------------------------------------------------------
    // register port request
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [31:0] wdata;
    } qcac_req_t;

    // ------------------------------------------------------------------------
    // divider states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        QCAC_DIV_IDLE = 2'b01,
        QCAC_DIV_RUN  = 2'b10
    } qcac_div_state_t;

endpackage

`default_nettype wire

// ==== verilog/qcac_top.sv ====
`default_nettype none

`include "qcac_map.svh"

module qcac_top #(
    parameter logic [20:0] STST_CYCLES = `QCAC_STST_CYCLES
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    input  wire logic [6:0]  REG_ADDR_I,
    input  wire logic [31:0] REG_WDATA_I,
    input  wire logic        STEP_I,
    input  wire logic        QUIET_ACTIVE_I,
    input  wire logic [4:0]  CUR_SCALE_I,
    input  wire logic [4:0]  LOW_SCALE_LIMIT_I,
    input  wire logic [7:0]  AUTO_AMPL_I,
    input  wire logic [7:0]  AUTO_SLOPE_I,
    input  wire logic        AUTO_SLOPE_VALID_I,
    input  wire logic [7:0]  OTP_SLOPE_I,
    input  wire logic        OTP_SLOPE_VALID_I,
    output logic [31:0]      REG_RDATA_O,
    output logic             REG_RVALID_O,
    output logic             PWM_CYCLE_O,
    output logic [7:0]       BASE_AMPLITUDE_O,
    output logic [4:0]       CS_ACTUAL_O,
    output logic             STANDSTILL_O,
    output logic [7:0]       SEED_SLOPE_O,
    output qcac_pkg::qcac_cfg_t CFG_O
);
    import qcac_pkg::*;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [7:0] sat8(input logic [15:0] v);
        sat8 = (v > 16'h00FF) ? `QCAC_AMPL_MAX : v[7:0];
    endfunction

    function automatic logic [10:0] half_period(input logic [1:0] code);
        unique case (code)
            2'h0:    half_period = `QCAC_HALF_PERIOD_00;
            2'h1:    half_period = `QCAC_HALF_PERIOD_01;
            2'h2:    half_period = `QCAC_HALF_PERIOD_10;
            default: half_period = `QCAC_HALF_PERIOD_11;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    qcac_req_t   req;
    qcac_cfg_t   cfg_r;
    qcac_cfg_t   cfg_nxt;
    logic        otp_done_r;
    logic [7:0]  tuned_slope_r;
    logic        autoscale_d_r;
    logic [10:0] phase_r;
    logic [20:0] idle_cnt_r;
    logic        stst_r;
    logic [20:0] step_interval_time_r;
    logic [7:0]  vel_r;
    logic [4:0]  cs_r;
    logic        div_busy;
    logic        div_done;
    logic [15:0] div_quot;

    assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};

    // ------------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------------
    wire logic hit_cfg   = (req.addr == `QCAC_ADDR_AMPL_CONFIG);
    wire logic hit_state = (req.addr == `QCAC_ADDR_STATE_FLAGS);
    wire logic hit_tuned = (req.addr == `QCAC_ADDR_TUNED_SLOPE);
    wire logic cfg_wr    = req.wr && hit_cfg;
    wire logic otp_load  = !otp_done_r && OTP_SLOPE_VALID_I;

    // reserved bits 23:22 are held at zero
    always_comb begin
        cfg_nxt      = cfg_r;
        if (cfg_wr) begin
            cfg_nxt      = qcac_cfg_t'(req.wdata);
            cfg_nxt.rsvd = 2'h0;
        end
        if (otp_load && !cfg_wr) begin
            cfg_nxt.slope = OTP_SLOPE_I;
        end
    end

    // ------------------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cfg_r.offset    <= `QCAC_RST_OFS;
            cfg_r.slope     <= `QCAC_RST_GRAD;
            cfg_r.freq_sel  <= `QCAC_RST_FREQ;
            cfg_r.autoscale <= `QCAC_RST_AUTOSCALE;
            cfg_r.autograd  <= `QCAC_RST_AUTOGRAD;
            cfg_r.freewheel <= `QCAC_RST_FREEWHEEL;
            cfg_r.rsvd      <= 2'h0;
            cfg_r.regul     <= `QCAC_RST_REG;
            cfg_r.lim       <= `QCAC_RST_LIM;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // one-time slope load in the first cycle after reset release
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            otp_done_r <= 1'b0;
        end else begin
            otp_done_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // tuned slope readback
    // ------------------------------------------------------------------------
    wire logic autoscale_rise = cfg_r.autoscale && !autoscale_d_r;
    wire logic tune_take      = cfg_r.autoscale && cfg_r.autograd && !autoscale_rise
                                && AUTO_SLOPE_VALID_I;
    wire logic [7:0] tuned_nxt = tune_take ? AUTO_SLOPE_I : cfg_nxt.slope;
    wire logic       tuned_upd = !cfg_r.autoscale || !cfg_r.autograd || autoscale_rise
                                 || tune_take;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tuned_slope_r <= `QCAC_RST_GRAD;
            autoscale_d_r <= 1'b0;
        end else begin
            autoscale_d_r <= cfg_r.autoscale;
            if (tuned_upd) begin
                tuned_slope_r <= tuned_nxt;
            end
        end
    end

    // ------------------------------------------------------------------------
    // pwm period generator, counts in half clocks
    // ------------------------------------------------------------------------
    wire logic [10:0] period_half = half_period(cfg_r.freq_sel);
    wire logic [11:0] phase_sum   = {1'b0, phase_r} + 12'h002;
    wire logic        phase_wrap  = (phase_sum >= {1'b0, period_half});
    wire logic [11:0] phase_sub   = phase_sum - {1'b0, period_half};
    wire logic [10:0] phase_nxt   = phase_wrap ? phase_sub[10:0] : phase_sum[10:0];

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            phase_r     <= 11'h000;
            PWM_CYCLE_O <= 1'b0;
        end else begin
            phase_r     <= phase_nxt;
            PWM_CYCLE_O <= phase_wrap;
        end
    end

    // ------------------------------------------------------------------------
    // step interval and standstill
    // ------------------------------------------------------------------------
    wire logic        idle_full  = (idle_cnt_r >= STST_CYCLES - 21'h000001);
    wire logic [20:0] step_interval_time_meas = stst_r ? STST_CYCLES : (idle_cnt_r + 21'h000001);

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            idle_cnt_r <= 21'h000000;
            stst_r     <= 1'b0;
            step_interval_time_r    <= STST_CYCLES;
        end else if (STEP_I) begin
            idle_cnt_r <= 21'h000000;
            stst_r     <= 1'b0;
            step_interval_time_r    <= step_interval_time_meas;
        end else if (idle_full) begin
            stst_r     <= 1'b1;
            step_interval_time_r    <= STST_CYCLES;
        end else begin
            idle_cnt_r <= idle_cnt_r + 21'h000001;
        end
    end

    // ------------------------------------------------------------------------
    // velocity term: slope * 256 / step interval
    // ------------------------------------------------------------------------
    wire logic [15:0] vel_num = {cfg_r.slope, 8'h00};

    qcac_divider u_div (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RESET_N_I),
        .start_i (!div_busy),
        .num_i   (vel_num),
        .den_i   (step_interval_time_r),
        .busy_o  (div_busy),
        .done_o  (div_done),
        .quot_o  (div_quot)
    );

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            vel_r <= 8'h00;
        end else if (div_done) begin
            vel_r <= sat8(div_quot);
        end
    end

    // ------------------------------------------------------------------------
    // current scale and amplitude
    // ------------------------------------------------------------------------
    wire logic       floor_on = cfg_r.autoscale && (cfg_r.offset == 8'h00)
                                && (CUR_SCALE_I < LOW_SCALE_LIMIT_I);
    wire logic [4:0] cs_nxt   = floor_on ? LOW_SCALE_LIMIT_I : CUR_SCALE_I;

    wire logic [13:0] ofs_prod   = cfg_r.offset * ({1'b0, cs_r} + 6'h01);
    wire logic [15:0] ofs_scaled = {7'h00, ofs_prod[13:`QCAC_OFS_SHIFT]};
    wire logic [15:0] man_sum    = ofs_scaled + {8'h00, vel_r};
    wire logic [7:0]  man_ampl   = sat8(man_sum);
    wire logic [7:0]  ampl_nxt   = cfg_r.autoscale ? AUTO_AMPL_I : man_ampl;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cs_r       <= 5'h00;
            BASE_AMPLITUDE_O <= 8'h00;
        end else begin
            cs_r       <= cs_nxt;
            BASE_AMPLITUDE_O <= ampl_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // status word and read port
    // ------------------------------------------------------------------------
    logic [31:0] state_word;

    always_comb begin
        state_word                                = 32'h0000_0000;
        state_word[`QCAC_STST_BIT]                = stst_r;
        state_word[`QCAC_QUIET_BIT]               = QUIET_ACTIVE_I;
        state_word[`QCAC_CS_MSB:`QCAC_CS_LSB]     = cs_r;
    end

    wire logic [31:0] rd_mux = hit_state ? state_word :
                               hit_cfg   ? 32'(cfg_r) :
                               hit_tuned ? {24'h000000, tuned_slope_r} :
                                           32'h0000_0000;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            REG_RDATA_O  <= 32'h0000_0000;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= req.rd;
            if (req.rd) begin
                REG_RDATA_O <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------------
    // registered side outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            CS_ACTUAL_O  <= 5'h00;
            STANDSTILL_O <= 1'b0;
            SEED_SLOPE_O <= `QCAC_RST_GRAD;
            CFG_O        <= '0;
        end else begin
            CS_ACTUAL_O  <= cs_r;
            STANDSTILL_O <= stst_r;
            SEED_SLOPE_O <= tuned_slope_r;
            CFG_O        <= cfg_r;
        end
    end

endmodule

`default_nettype wire
